// File: sim/io_field_model.sv
// Model of the field switches and of the valve driver on output 0.
`timescale 1ns/1ps
module io_field_model (
  // Clock.
  input wire pclk,
  // Switch levels wanted by the bench and the wired inputs.
  input wire [7:0] sw_level,
  output reg [7:0] in_pin,
  // Valve drive and its count of switch-on events.
  input wire valve,
  output reg [15:0] rises
);
  reg valve_q;
  initial begin
    in_pin = 8'h00;
    rises = 16'h0000;
    valve_q = 1'b0;
  end
  // Contacts settle one clock after the bench asks; each valve pull-in is counted.
  always @(posedge pclk) begin
    in_pin <= sw_level;
    valve_q <= valve;
    if (valve && !valve_q) begin
      rises <= rises + 16'h0001;
    end
  end
endmodule

// File: sim/io_signal_conditioning_monitor.sv
// Checker for bus timing and pin behaviour of the conditioning block.
`timescale 1ns/1ps
module io_signal_conditioning_monitor #(
  parameter N_IN = 8,
  parameter N_OUT = 8
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Register bus.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Pins.
  input wire [N_IN-1:0] in_pin,
  input wire [15:0] vin,
  input wire [15:0] vout,
  input wire [N_OUT-1:0] out_pin
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Access phase of a transfer.
  wire acc = psel && penable;
  // ***
  // Bus rules
  // ***
  property p_ready;
    pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err_idle;
    !acc |-> !pslverr;
  endproperty
  a_err_idle: assert property (p_err_idle) else $error("error outside access");
  property p_err_bad;
    acc && paddr == 8'h20 |-> pslverr;
  endproperty
  a_err_bad: assert property (p_err_bad) else $error("no error on hole");
  property p_err_ok;
    acc && paddr <= 8'h10 && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_err_ok: assert property (p_err_ok) else $error("error on register");
  property p_rd_bad;
    acc && !pwrite && paddr == 8'h20 |-> prdata == 32'h00000000;
  endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("hole read not zero");
  // Read data must not move once presented; it only reloads at a setup cycle.
  property p_rd_hold;
    acc && !pwrite |=> $stable(prdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  // ***
  // Pin rules
  // ***
  property p_rst_clear;
    $rose(presetn) |-> out_pin == '0 && vin == 16'h0000;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("pins not off");
  // Quiet bus and steady pins leave the virtual inputs still, three stages deep on the toggle path.
  property p_vin_steady;
    (!psel && $stable(in_pin)) [*5] |=> $stable(vin);
  endproperty
  a_vin_steady: assert property (p_vin_steady) else $error("vin moved");
  c_wr: cover property (acc && pwrite);
  c_rd: cover property (acc && !pwrite);
  c_err: cover property (acc && pslverr);
  c_pin: cover property ($rose(out_pin[0]));
endmodule
bind io_signal_conditioning io_signal_conditioning_monitor #(.N_IN(N_IN), .N_OUT(N_OUT))
  io_signal_conditioning_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .in_pin(in_pin), .vin(vin), .vout(vout),
  .out_pin(out_pin));

// File: sim/test_io_signal_conditioning.sv
// Self-checking bench for the conditioning block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares = compares + 1; if ((g) !== (e)) begin \
  n_mismatch = n_mismatch + 1; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_io_signal_conditioning;
  // Tick kept short so chopping periods stay cheap to simulate.
  localparam TK = 4;
  localparam [63:0] ON_T = {8'd12, 8'd20, 8'd20, 8'd20, 8'd20, 8'd40, 8'd40, 8'd80};
  localparam [63:0] OFF_T = {8'd8, 8'd220, 8'd100, 8'd40, 8'd20, 8'd40, 8'd20, 8'd40};
  reg pclk, presetn, psel, penable, pwrite, err;
  reg [7:0] paddr, sw;
  reg [31:0] pwdata, rd;
  reg [15:0] vout, r0;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [7:0] in_pin, out_pin;
  wire [15:0] vin, rises;
  integer n_mismatch, compares, i;
  io_signal_conditioning #(.N_IN(8), .N_OUT(8), .TICK_CYCLES(TK)) io_signal_conditioning_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_pin(in_pin), .vin(vin), .vout(vout), .out_pin(out_pin));
  io_field_model io_field_model_inst (.pclk(pclk), .sw_level(sw), .in_pin(in_pin),
    .valve(out_pin[0]), .rises(rises));
  // ***
  // Bus and timing helpers
  // ***
  // One APB transfer; an idle edge first keeps back-to-back calls legal.
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait states are left to the slave; only the watchdog ends a stuck wait.
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      `CHK("pready", 1'b1, pready)
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task end_of_test;
    begin
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Whole run needs about 2200 cycles; 20000 means a hang.
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    end_of_test;
  end
  // ***
  // Scenarios
  // ***
  initial begin
    {presetn, psel, penable, pwrite, paddr, sw, pwdata, vout} = 0;
    n_mismatch = 0;
    compares = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("out", 8'h00, out_pin)
    `CHK("vin", 16'h0000, vin)
    // Alternate output first, while its state is still fresh from reset.
    xfer(1, 8'h40, 32'h00000011);
    vout <= 16'h0002;
    cyc(3);
    `CHK("alt1", 1'b1, out_pin[0])
    vout <= 16'h0000;
    cyc(3);
    `CHK("alt2", 1'b1, out_pin[0])
    vout <= 16'h0002;
    cyc(3);
    `CHK("alt3", 1'b0, out_pin[0])
    // Register access, read-only status and an unmapped hole.
    xfer(1, 8'h00, 32'h0000005a);
    xfer(0, 8'h00, 0);
    `CHK("inv", 32'h0000005a, rd)
    xfer(1, 8'h10, 32'hffffffff);
    xfer(0, 8'h10, 0);
    `CHK("slot", 8'h5a, rd[7:0])
    `CHK("ro", 16'h0000, rd[31:16])
    xfer(0, 8'h20, 0);
    `CHK("hole", 32'h00000000, rd)
    `CHK("err", 1'b1, err)
    // Input path: identity map, inverted upper nibble.
    xfer(1, 8'h08, 32'h76543210);
    xfer(1, 8'h00, 32'h000000f0);
    sw <= 8'h3c;
    cyc(4);
    `CHK("vin map", 16'h00cc, vin)
    xfer(1, 8'h00, 0);
    xfer(1, 8'h04, 32'h00000001);
    for (i = 0; i < 2; i = i + 1) begin
      sw <= 8'h01;
      cyc(2);
      sw <= 8'h00;
      cyc(4);
      `CHK("in alt", ~i[0], vin[0])
    end
    // Plain output, then reversed.
    vout <= 16'h0000;
    xfer(1, 8'h40, 32'h00000001);
    vout <= 16'h0002;
    cyc(3);
    `CHK("route", 8'h01, out_pin)
    xfer(1, 8'h40, 32'h00000081);
    cyc(2);
    `CHK("rev", 1'b0, out_pin[0])
    // ON delay of 5 ticks, then OFF delay of 5 ticks.
    vout <= 16'h0000;
    xfer(1, 8'h44, 32'h00050005);
    xfer(1, 8'h40, 32'h00000021);
    vout <= 16'h0002;
    cyc(12);
    `CHK("on early", 1'b0, out_pin[0])
    cyc(14);
    `CHK("on late", 1'b1, out_pin[0])
    xfer(1, 8'h40, 32'h00000041);
    vout <= 16'h0000;
    cyc(12);
    `CHK("off early", 1'b1, out_pin[0])
    cyc(14);
    `CHK("off late", 1'b0, out_pin[0])
    // Every fixed and the manual chopping duty, with a one-tick full-wave lead.
    xfer(1, 8'h0c, 32'h0008000c);
    for (i = 1; i < 9; i = i + 1) begin
      vout <= 16'h0000;
      xfer(1, 8'h40, 32'h00010001 | (i << 8));
      r0 = rises;
      vout <= 16'h0002;
      cyc(TK * (1 + ON_T[8*i-8 +: 8] / 2));
      `CHK("chop on", 1'b1, out_pin[0])
      cyc(TK * (ON_T[8*i-8 +: 8] + OFF_T[8*i-8 +: 8]) / 2);
      `CHK("chop off", 1'b0, out_pin[0])
      `CHK("rises", r0 + 16'h0001, rises)
    end
    // Reset in mid-run while the manual duty is in its on phase.
    cyc(TK * 8);
    `CHK("pre rst", 1'b1, out_pin[0])
    presetn <= 1'b0;
    cyc(2);
    `CHK("rst out", 8'h00, out_pin)
    `CHK("rst vin", 16'h0000, vin)
    presetn <= 1'b1;
    cyc(2);
    xfer(0, 8'h40, 0);
    `CHK("rst cfg", 32'h00000000, rd)
    `CHK("rst hold", 8'h00, out_pin)
    end_of_test;
  end
endmodule

// File: verilog/io_signal_conditioning.v
// Discrete input and output signal conditioning with an APB register file.
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "io_signal_conditioning_defs.vh"
// How it works
// RQ1 - Input logic stage inverts raw input optionally
// RQ2 - Input toggle flips on each rising edge
// RQ3 - Raw, logic, operation, then physical slot
// RQ4 - Each slot drives its chosen virtual input
// RQ5 - Each output picks one virtual output source
// RQ6 - Output toggle stage, on at first edge
// RQ7 - ON delay holds rise for count ticks
// RQ8 - OFF delay extends on for count ticks
// RQ9 - Disabled delay passes its input through
// RQ10 - Output logic stage optionally inverts delayed signal
// RQ11 - Full-on chopping passes signal unchanged
// RQ12 - Other chopping: full-wave time, then square wave
// RQ13 - Seven fixed duties, full-on and manual
// RQ14 - Toggle, ON, OFF, logic, chopping, then pin
// RQ15 - One 100 us tick counts all periods
// RQ16 - Reset clears every stage to off
module io_signal_conditioning #(
  parameter N_IN = 8,
  parameter N_OUT = 8,
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Raw input ports and virtual inputs towards machine control.
  input wire [N_IN-1:0] in_pin,
  output wire [15:0] vin,
  // Virtual outputs from machine control and output port pins.
  input wire [15:0] vout,
  output wire [N_OUT-1:0] out_pin
);

  // ****************************************
  // Chopping states
  // ****************************************
  localparam CH_IDLE = 2'b00;
  localparam CH_FULL = 2'b01;
  localparam CH_ON = 2'b10;
  localparam CH_OFF = 2'b11;
  // The tick counter is 15 bits wide, so a tick may last at most 32768 cycles.
  localparam [31:0] TICK_FULL = TICK_CYCLES - 1;
  localparam [14:0] TICK_LAST = TICK_FULL[14:0];

  // ****************************************
  // Time base
  // ****************************************
  reg [14:0] tick_cnt_reg; // Cycles into the current tick.
  reg tick_reg; // One-cycle pulse every 100 us.

  // A single shared tick keeps all outputs in step; each period is accurate to one tick.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 15'h0000;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == TICK_LAST) begin
      tick_cnt_reg <= 15'h0000; // RQ15
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 15'h0001;
      tick_reg <= 1'b0;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  reg [31:0] in_inv_reg; // Per-input reverse setting.
  reg [31:0] in_tog_reg; // Per-input alternate setting.
  reg [31:0] in_map_reg; // Four-bit virtual index per slot.
  reg [31:0] manual_reg; // Manual duty on and off ticks.
  reg [31:0] ocfg_reg [0:N_OUT-1]; // Output stage configuration.
  reg [31:0] odly_reg [0:N_OUT-1]; // Output ON and OFF delay counts.
  reg [31:0] prdata_reg; // Read data captured in the setup cycle.
  wire [N_IN-1:0] slot; // Physical input slots, one flip-flop per channel.
  reg [15:0] vin_reg; // Virtual inputs.
  wire [N_OUT-1:0] pin; // Output pins, one flip-flop per channel.
  wire out_hit; // Address falls in the output window.
  wire [2:0] out_idx; // Output selected by the address.
  wire mapped; // Address is a known register.
  wire wr_en; // Write takes effect in this access cycle.
  integer i;

  assign out_hit = (paddr[7:6] == 2'b01) && ({2'b00, paddr[5:3]} < N_OUT);
  assign out_idx = paddr[5:3];
  assign mapped = out_hit || (paddr == `REG_IN_INVERT) || (paddr == `REG_IN_TOGGLE) ||
                  (paddr == `REG_IN_MAP) || (paddr == `REG_MANUAL) || (paddr == `REG_STATUS);
  assign wr_en = psel && penable && pwrite && mapped;
  // The slave never stalls; an unmapped address answers with an error.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;

  // Writes land at the access edge; unmapped writes are dropped.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_inv_reg <= `RST_WORD;
      in_tog_reg <= `RST_WORD;
      in_map_reg <= `RST_WORD;
      manual_reg <= `RST_WORD;
      for (i = 0; i < N_OUT; i = i + 1) begin
        ocfg_reg[i] <= `RST_WORD;
        odly_reg[i] <= `RST_WORD;
      end
    end else if (wr_en) begin
      if (out_hit) begin
        if (paddr[2]) begin
          odly_reg[out_idx] <= pwdata;
        end else begin
          ocfg_reg[out_idx] <= pwdata;
        end
      end else if (paddr == `REG_IN_INVERT) begin
        in_inv_reg <= pwdata;
      end else if (paddr == `REG_IN_TOGGLE) begin
        in_tog_reg <= pwdata;
      end else if (paddr == `REG_IN_MAP) begin
        in_map_reg <= pwdata;
      end else if (paddr == `REG_MANUAL) begin
        manual_reg <= pwdata;
      end
    end
  end

  // Read data is captured in the setup cycle so it comes from a flip-flop in the access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= `RST_WORD;
    end else if (psel && !penable) begin
      if (out_hit) begin
        prdata_reg <= paddr[2] ? odly_reg[out_idx] : ocfg_reg[out_idx];
      end else if (paddr == `REG_IN_INVERT) begin
        prdata_reg <= in_inv_reg;
      end else if (paddr == `REG_IN_TOGGLE) begin
        prdata_reg <= in_tog_reg;
      end else if (paddr == `REG_IN_MAP) begin
        prdata_reg <= in_map_reg;
      end else if (paddr == `REG_MANUAL) begin
        prdata_reg <= manual_reg;
      end else if (paddr == `REG_STATUS) begin
        prdata_reg <= {16'h0000, 8'h00 | pin, 8'h00 | slot};
      end else begin
        prdata_reg <= `RST_WORD;
      end
    end
  end

  // ****************************************
  // Input control section
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < N_IN; g = g + 1) begin : in_ch
      wire logic_b; // After the logic stage.
      reg prev_reg; // Logic stage one cycle ago.
      reg alt_reg; // Alternate state.
      reg slot_reg; // Physical slot of this channel.
      assign slot[g] = slot_reg;
      assign logic_b = in_pin[g] ^ in_inv_reg[g]; // RQ1
      // Toggle and slot update; both start off after reset.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev_reg <= 1'b0; // RQ16
          alt_reg <= 1'b0;
          slot_reg <= 1'b0;
        end else begin
          prev_reg <= logic_b;
          if (!in_tog_reg[g]) begin
            // Normal operation parks the toggle off, so the first edge after enabling turns on.
            alt_reg <= 1'b0;
          end else if (logic_b && !prev_reg) begin
            alt_reg <= !alt_reg; // RQ2
          end
          slot_reg <= in_tog_reg[g] ? alt_reg : logic_b; // RQ3
        end
      end
    end
  endgenerate

  // Several slots may name one virtual input; they are OR-ed together.
  reg [15:0] vin_next;
  integer j;
  always @* begin
    vin_next = 16'h0000;
    for (j = 0; j < N_IN; j = j + 1) begin
      vin_next[in_map_reg[4*j +: 4]] = vin_next[in_map_reg[4*j +: 4]] | slot[j]; // RQ4
    end
  end

  // Virtual inputs are registered so machine control sees a glitch-free word.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vin_reg <= 16'h0000;
    end else begin
      vin_reg <= vin_next;
    end
  end
  assign vin = vin_reg;

  // ****************************************
  // Output control section
  // ****************************************
  // Duty period lookup; manual entry comes from the manual register.
  function [15:0] duty_len;
    input [3:0] sel;
    input off_half;
    input [31:0] man;
    begin
      case (sel)
        `DUTY_8_4: duty_len = off_half ? `T_4MS : `T_8MS; // RQ13
        `DUTY_4_2: duty_len = off_half ? `T_2MS : `T_4MS;
        `DUTY_4_4: duty_len = `T_4MS;
        `DUTY_2_2: duty_len = `T_2MS;
        `DUTY_2_4: duty_len = off_half ? `T_4MS : `T_2MS;
        `DUTY_2_10: duty_len = off_half ? `T_10MS : `T_2MS;
        `DUTY_2_22: duty_len = off_half ? `T_22MS : `T_2MS;
        default: duty_len = off_half ? man[`MAN_OFF] : man[`MAN_ON];
      endcase
    end
  endfunction

  generate
    for (g = 0; g < N_OUT; g = g + 1) begin : out_ch
      wire [31:0] cfg = ocfg_reg[g];
      wire [31:0] dly = odly_reg[g];
      wire src = vout[cfg[`OC_SRC]]; // RQ5
      wire sa; // Toggle stage output.
      wire sb; // ON delay output.
      wire sc; // OFF delay output.
      wire sd; // Logic stage output.
      wire se; // Chopping output.
      wire full_on = (cfg[`OC_DUTY] == `DUTY_FULL);
      reg src_prev_reg, alt_reg, on_reg, off_reg; // Edge memory, toggle and delay states.
      reg pin_reg; // Pin flip-flop of this channel.
      assign pin[g] = pin_reg;
      reg [15:0] on_cnt_reg, off_cnt_reg, ch_cnt_reg;
      reg [1:0] ch_state_reg;
      wire [15:0] ch_lim = (ch_state_reg == CH_FULL) ? {4'h0, cfg[`OC_FULL]} :
                           duty_len(cfg[`OC_DUTY], ch_state_reg == CH_OFF, manual_reg);

      assign sa = cfg[`OC_ALT] ? alt_reg : src; // RQ6
      assign sb = cfg[`OC_ON_EN] ? on_reg : sa; // RQ9
      assign sc = cfg[`OC_OFF_EN] ? (sb | off_reg) : sb; // RQ9
      assign sd = sc ^ cfg[`OC_REV]; // RQ10
      assign se = full_on ? sd : (ch_state_reg != CH_IDLE) && (ch_state_reg != CH_OFF); // RQ11

      // Toggle, delays and pin.  A changed count applies at once, also to a delay that is already counting.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          src_prev_reg <= 1'b0; // RQ16
          alt_reg <= 1'b0;
          on_reg <= 1'b0;
          off_reg <= 1'b0;
          on_cnt_reg <= 16'h0000;
          off_cnt_reg <= 16'h0000;
          pin_reg <= 1'b0;
        end else begin
          src_prev_reg <= src;
          if (!cfg[`OC_ALT]) begin
            alt_reg <= 1'b0; // Parked off so alternate always starts with on.
          end else if (src && !src_prev_reg) begin
            alt_reg <= !alt_reg; // RQ6
          end
          if (!sa) begin
            on_reg <= 1'b0;
            on_cnt_reg <= 16'h0000;
          end else if (!on_reg && on_cnt_reg >= dly[`OD_ON]) begin
            on_reg <= 1'b1; // RQ7
          end else if (!on_reg && tick_reg) begin
            on_cnt_reg <= on_cnt_reg + 16'h0001; // RQ15
          end
          if (sb) begin
            off_reg <= 1'b1;
            off_cnt_reg <= 16'h0000;
          end else if (off_reg && off_cnt_reg >= dly[`OD_OFF]) begin
            off_reg <= 1'b0; // RQ8
          end else if (off_reg && tick_reg) begin
            off_cnt_reg <= off_cnt_reg + 16'h0001;
          end
          pin_reg <= se; // RQ14
        end
      end

      // Chopping: full-wave hold after each rise of the logic stage, then on and off phases.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ch_state_reg <= CH_IDLE; // RQ16
          ch_cnt_reg <= 16'h0000;
        end else begin
          if (!sd || full_on) begin
            ch_state_reg <= CH_IDLE;
            ch_cnt_reg <= 16'h0000;
          end else begin
            case (ch_state_reg)
              CH_IDLE: begin
                ch_state_reg <= CH_FULL; // RQ12
                ch_cnt_reg <= 16'h0000;
              end
              default: begin
                if (ch_cnt_reg >= ch_lim) begin
                  ch_state_reg <= (ch_state_reg == CH_ON) ? CH_OFF : CH_ON; // RQ12
                  ch_cnt_reg <= 16'h0000;
                end else if (tick_reg) begin
                  ch_cnt_reg <= ch_cnt_reg + 16'h0001;
                end
              end
            endcase
          end
        end
      end
    end
  endgenerate

  assign out_pin = pin;

endmodule

// File: verilog/io_signal_conditioning_defs.vh
// Constants for the discrete input and output conditioning block.
`ifndef IO_SIGNAL_CONDITIONING_DEFS_VH
`define IO_SIGNAL_CONDITIONING_DEFS_VH

// ****************************************
// Time base
// ****************************************
`define CLK_MHZ 200
`define TICK_TIME_US 100
`define TICK_CYCLES (`TICK_TIME_US * `CLK_MHZ)

// ****************************************
// Register byte offsets
// ****************************************
`define REG_IN_INVERT 8'h00
`define REG_IN_TOGGLE 8'h04
`define REG_IN_MAP 8'h08
`define REG_MANUAL 8'h0c
`define REG_STATUS 8'h10
`define REG_OUT_BASE 8'h40

// ****************************************
// Output configuration fields
// ****************************************
`define OC_SRC 3:0
`define OC_ALT 4
`define OC_ON_EN 5
`define OC_OFF_EN 6
`define OC_REV 7
`define OC_DUTY 11:8
`define OC_FULL 27:16
`define OD_ON 15:0
`define OD_OFF 31:16
`define MAN_ON 15:0
`define MAN_OFF 31:16

// ****************************************
// Duty choices and their periods in ticks
// ****************************************
`define DUTY_FULL 4'h0
`define DUTY_8_4 4'h1
`define DUTY_4_2 4'h2
`define DUTY_4_4 4'h3
`define DUTY_2_2 4'h4
`define DUTY_2_4 4'h5
`define DUTY_2_10 4'h6
`define DUTY_2_22 4'h7
`define DUTY_MANUAL 4'h8
`define T_2MS 16'h0014
`define T_4MS 16'h0028
`define T_8MS 16'h0050
`define T_10MS 16'h0064
`define T_22MS 16'h00dc

// ****************************************
// Reset values
// ****************************************
`define RST_WORD 32'h00000000

`endif
